// file: pkg/dma_status_map.svh
`ifndef DMA_STATUS_MAP_SVH
`define DMA_STATUS_MAP_SVH
// Byte offsets of the channel registers.
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_NEXT_A 8'h08
`define OFS_NEXT_B 8'h0c
`define OFS_NEXT_LEN 8'h10
`define OFS_WORK_A 8'h14
`define OFS_WORK_B 8'h18
`define OFS_COUNTER 8'h1c
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_CLEAR 8'h24
`define OFS_IRQ_ENABLE 8'h28
// Field positions.
`define BIT_TC 0
`define BIT_OVR 1
`define BIT_CHANNEL_ACTIVE_FLAG 2
`define BIT_VLD 3
`define BIT_CHANNEL_ENABLE_BIT 0
`define BIT_ETC 1
`define BIT_OVERRUN_IRQ_ENABLE 2
`define BIT_IND 4
`define BIT_OT 6
`define BIT_IRQ_TC 0
`define BIT_IRQ_OVR 1
// Widths and reset values.
`define ADDR_W 24
`define LEN_W 16
`define ZERO_WORD 32'h0000_0000
`define ZERO_ADDR 24'h00_0000
`define ZERO_LEN 16'h0000
`define ONE_LEN 16'h0001
`endif

// file: pkg/dma_status_pkg.sv
package dma_status_pkg;
    // Channel controls kept by software.
    typedef struct packed {
        logic operation_type_sel;
        logic indirect_sel;
        logic overrun_irq_enable;
        logic block_done_irq_enable;
        logic channel_enable_bit;
    } control_t;
    // Sticky and live channel flags.
    typedef struct packed {
        logic next_params_valid_flag;
        logic channel_active_flag;
        logic overrun_flag;
        logic block_done_flag;
    } status_t;
    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

// file: logic/dma_channel_status_logic.sv
`timescale 1ns/10ps
`include "dma_status_map.svh"
// How it works
// R1 - Block ending with the counter reaching zero sets the block done flag.
// R2 - Buffered mode: block end while valid flag clear sets overrun.
// R3 - Auto-initialize mode: block end while block done still set sets overrun.
// R4 - Single-buffer uses the buffered overrun rule; software keeps valid clear.
// R5 - Active flag is high exactly when enabled and counter above zero.
// R6 - Active flag is read only; software writes to it are dropped.
// R7 - Every write of the next block length sets the valid flag.
// R8 - Taking over next parameters at block end clears the valid flag.
// R9 - Reload copies A address and length; B address only when indirect.
// R10 - Writing one to the valid bit clears it.
// R11 - Valid, overrun, block done are sticky; write-one clears them, and take-over at block end also clears valid.
// R12 - Counter drops by one after every transfer cycle above zero; a take-over at block end loads the next length instead.
// R13 - Overrun raises the interrupt only while its enable is set.
// R14 - Status clears at reset; reserved bits read as zero.
// R15 - Interrupt is enabled block done OR enabled overrun, held while set.
// R16 - Hardware set beats a same-cycle software clear.
module dma_channel_status_logic
    import dma_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic xfer_done_i,
    output logic channel_active_o,
    output logic irq_o,
    output logic [`ADDR_W-1:0] working_dev_a_address_o,
    output logic [`ADDR_W-1:0] working_dev_b_address_o,
    output logic [`LEN_W-1:0] remaining_transfer_counter_o
);
    bus_state_t bus_state;
    control_t ctrl;
    status_t status;
    logic [`ADDR_W-1:0] next_dev_a_address;
    logic [`ADDR_W-1:0] next_dev_b_address;
    logic [`LEN_W-1:0] next_block_length_reg;
    logic [`LEN_W-1:0] counter;
    logic wr_go;
    logic rd_take;
    logic [31:0] wdata;
    logic blk_end;
    logic reload;
    logic status_clr_tc;
    logic status_clr_ovr;
    logic status_clr_vld;
    logic len_write;
    logic set_ovr;
    logic next_enable;
    logic [`LEN_W-1:0] next_counter;

    // Merges write data into an old word under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // True for a write that lands on the given offset this cycle.
    function automatic logic hit(input logic go, input logic [7:0] a, input logic [7:0] ofs);
        return go && (a == ofs);
    endfunction

    // A request is served one cycle after it is seen; writes land on the answer edge.
    assign wr_go = avs_write_i && (bus_state == BUS_ANSWER);
    assign rd_take = (avs_read_i || avs_write_i) && (bus_state == BUS_IDLE);
    assign wdata = merge(`ZERO_WORD, avs_writedata_i, avs_byteenable_i);

    // Bus handshake: waitrequest stays high except on the answer cycle.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_state <= BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
        end else begin
            unique case (bus_state)
                BUS_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_state <= BUS_ANSWER;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                BUS_ANSWER: begin
                    bus_state <= BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // Read data is captured one edge early so it stands on the answer edge.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= `ZERO_WORD;
        end else if (rd_take) begin
            unique case (avs_address_i)
                `OFS_CONTROL: avs_readdata_o <= {25'h000_0000, ctrl.operation_type_sel, 1'b0,
                    ctrl.indirect_sel, 1'b0, ctrl.overrun_irq_enable,
                    ctrl.block_done_irq_enable, ctrl.channel_enable_bit};
                // R14 reserved read zero
                `OFS_STATUS: avs_readdata_o <= {28'h000_0000, status};
                `OFS_NEXT_A: avs_readdata_o <= {8'h00, next_dev_a_address};
                `OFS_NEXT_B: avs_readdata_o <= {8'h00, next_dev_b_address};
                `OFS_NEXT_LEN: avs_readdata_o <= {16'h0000, next_block_length_reg};
                `OFS_WORK_A: avs_readdata_o <= {8'h00, working_dev_a_address_o};
                `OFS_WORK_B: avs_readdata_o <= {8'h00, working_dev_b_address_o};
                `OFS_COUNTER: avs_readdata_o <= {16'h0000, counter};
                `OFS_IRQ_STATUS: avs_readdata_o <= {30'h0000_0000, status.overrun_flag,
                    status.block_done_flag};
                `OFS_IRQ_ENABLE: avs_readdata_o <= {30'h0000_0000, ctrl.overrun_irq_enable,
                    ctrl.block_done_irq_enable};
                default: avs_readdata_o <= `ZERO_WORD;
            endcase
        end
    end

    // Control register, with the interrupt enables also reachable by their own alias.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl <= '0;
        end else if (hit(wr_go, avs_address_i, `OFS_CONTROL) && avs_byteenable_i[0]) begin
            ctrl.channel_enable_bit <= wdata[`BIT_CHANNEL_ENABLE_BIT];
            ctrl.block_done_irq_enable <= wdata[`BIT_ETC];
            ctrl.overrun_irq_enable <= wdata[`BIT_OVERRUN_IRQ_ENABLE];
            ctrl.indirect_sel <= wdata[`BIT_IND];
            ctrl.operation_type_sel <= wdata[`BIT_OT];
        end else if (hit(wr_go, avs_address_i, `OFS_IRQ_ENABLE) && avs_byteenable_i[0]) begin
            ctrl.block_done_irq_enable <= wdata[`BIT_IRQ_TC];
            ctrl.overrun_irq_enable <= wdata[`BIT_IRQ_OVR];
        end
    end

    // Next block parameters written by software.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            next_dev_a_address <= `ZERO_ADDR;
            next_dev_b_address <= `ZERO_ADDR;
            next_block_length_reg <= `ZERO_LEN;
        end else begin
            if (hit(wr_go, avs_address_i, `OFS_NEXT_A)) begin
                next_dev_a_address <= `ADDR_W'(merge({8'h00, next_dev_a_address},
                    avs_writedata_i, avs_byteenable_i));
            end
            if (hit(wr_go, avs_address_i, `OFS_NEXT_B)) begin
                next_dev_b_address <= `ADDR_W'(merge({8'h00, next_dev_b_address},
                    avs_writedata_i, avs_byteenable_i));
            end
            if (len_write) begin
                next_block_length_reg <= `LEN_W'(merge({16'h0000, next_block_length_reg},
                    avs_writedata_i, avs_byteenable_i));
            end
        end
    end

    // Block end is the transfer that takes the counter to zero.
    // R1 zero reached
    assign blk_end = xfer_done_i && (counter == `ONE_LEN);
    // R8 take over
    assign reload = blk_end && status.next_params_valid_flag;
    assign len_write = hit(wr_go, avs_address_i, `OFS_NEXT_LEN);
    // R6 channel_active_flag bit ignored
    assign status_clr_tc = (hit(wr_go, avs_address_i, `OFS_STATUS)
        && wdata[`BIT_TC]) || (hit(wr_go, avs_address_i, `OFS_IRQ_CLEAR)
        && wdata[`BIT_IRQ_TC]);
    assign status_clr_ovr = (hit(wr_go, avs_address_i, `OFS_STATUS)
        && wdata[`BIT_OVR]) || (hit(wr_go, avs_address_i, `OFS_IRQ_CLEAR)
        && wdata[`BIT_IRQ_OVR]);
    // R10 write one clears
    assign status_clr_vld = hit(wr_go, avs_address_i, `OFS_STATUS) && wdata[`BIT_VLD];

    // Overrun cause depends on the operation type; single-buffer shares the buffered rule.
    // R2 R3 R4 overrun cause
    assign set_ovr = blk_end && (ctrl.operation_type_sel ? status.block_done_flag
        : !status.next_params_valid_flag);

    // Counter: software load, reload at block end, else one step per transfer.
    always_comb begin
        next_counter = counter;
        if (hit(wr_go, avs_address_i, `OFS_COUNTER)) begin
            next_counter = `LEN_W'(merge({16'h0000, counter}, avs_writedata_i,
                avs_byteenable_i));
        // R9 length copied
        end else if (reload) begin
            next_counter = next_block_length_reg;
        // R12 step down
        end else if (xfer_done_i && counter != `ZERO_LEN) begin
            next_counter = counter - `ONE_LEN;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            counter <= `ZERO_LEN;
        end else begin
            counter <= next_counter;
        end
    end
    assign remaining_transfer_counter_o = counter;

    // Working addresses; B is only taken over on memory-to-memory transfers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            working_dev_a_address_o <= `ZERO_ADDR;
            working_dev_b_address_o <= `ZERO_ADDR;
        // R9 address copy
        end else if (reload) begin
            working_dev_a_address_o <= next_dev_a_address;
            if (ctrl.indirect_sel) begin
                working_dev_b_address_o <= next_dev_b_address;
            end
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins.
    // R11 R16 sticky set wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status.block_done_flag <= 1'b0;
            status.overrun_flag <= 1'b0;
            status.next_params_valid_flag <= 1'b0;
            status.channel_active_flag <= 1'b0;
        end else begin
            // R5 live status copy
            status.channel_active_flag <= next_enable && (next_counter != `ZERO_LEN);
            status.block_done_flag <= (status.block_done_flag && !status_clr_tc) || blk_end;
            status.overrun_flag <= (status.overrun_flag && !status_clr_ovr) || set_ovr;
            // R7 R8 valid set and clear
            status.next_params_valid_flag <= (status.next_params_valid_flag
                && !status_clr_vld && !reload) || len_write;
        end
    end

    // Active flag follows the next enable and counter so it matches them each cycle.
    assign next_enable = hit(wr_go, avs_address_i, `OFS_CONTROL) && avs_byteenable_i[0]
        ? wdata[`BIT_CHANNEL_ENABLE_BIT] : ctrl.channel_enable_bit;
    // R5 live active
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            channel_active_o <= 1'b0;
        end else begin
            channel_active_o <= next_enable && (next_counter != `ZERO_LEN);
        end
    end

    // Level interrupt from enabled sticky flags.
    // R13 R15 gated request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (status.block_done_flag && ctrl.block_done_irq_enable)
                || (status.overrun_flag && ctrl.overrun_irq_enable);
        end
    end

    // Checks.
    sequence s_status_read;
        avs_read_i && bus_state == BUS_IDLE && avs_address_i == `OFS_STATUS;
    endsequence
    property p_active;
        @(posedge clk_i) disable iff (!rst_n_i)
        channel_active_o == (ctrl.channel_enable_bit && counter != `ZERO_LEN);
    endproperty
    a_active: assert property (p_active) else $error("active flag mismatch"); // R5
    property p_tc;
        @(posedge clk_i) disable iff (!rst_n_i) blk_end |=> status.block_done_flag;
    endproperty
    a_tc: assert property (p_tc) else $error("block done not set"); // R1
    property p_ovr_buf;
        @(posedge clk_i) disable iff (!rst_n_i)
        blk_end && !ctrl.operation_type_sel && !status.next_params_valid_flag
        |=> status.overrun_flag;
    endproperty
    a_ovr_buf: assert property (p_ovr_buf) else $error("buffered overrun missed"); // R2
    property p_ovr_auto;
        @(posedge clk_i) disable iff (!rst_n_i)
        blk_end && ctrl.operation_type_sel && status.block_done_flag |=> status.overrun_flag;
    endproperty
    a_ovr_auto: assert property (p_ovr_auto) else $error("auto overrun missed"); // R3
    property p_vld_set;
        @(posedge clk_i) disable iff (!rst_n_i) len_write |=> status.next_params_valid_flag;
    endproperty
    a_vld_set: assert property (p_vld_set) else $error("valid not set"); // R7
    property p_vld_take;
        @(posedge clk_i) disable iff (!rst_n_i)
        reload && !len_write |=> !status.next_params_valid_flag;
    endproperty
    a_vld_take: assert property (p_vld_take) else $error("valid not cleared"); // R8
    property p_reload;
        @(posedge clk_i) disable iff (!rst_n_i)
        reload && !hit(wr_go, avs_address_i, `OFS_COUNTER)
        |=> counter == $past(next_block_length_reg)
            && working_dev_a_address_o == $past(next_dev_a_address);
    endproperty
    a_reload: assert property (p_reload) else $error("reload wrong"); // R9
    property p_step;
        @(posedge clk_i) disable iff (!rst_n_i)
        xfer_done_i && counter > `ONE_LEN && !hit(wr_go, avs_address_i, `OFS_COUNTER)
        |=> counter == $past(counter) - `ONE_LEN;
    endproperty
    a_step: assert property (p_step) else $error("counter step wrong"); // R12
    property p_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        status.overrun_flag && ctrl.overrun_irq_enable |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("overrun irq missing"); // R13
    property p_irq_off;
        @(posedge clk_i) disable iff (!rst_n_i)
        !(status.block_done_flag && ctrl.block_done_irq_enable)
        && !(status.overrun_flag && ctrl.overrun_irq_enable) |=> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("spurious irq"); // R15
    property p_sticky;
        @(posedge clk_i) disable iff (!rst_n_i)
        status.overrun_flag && !status_clr_ovr |=> status.overrun_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("overrun lost"); // R11
    property p_set_wins;
        @(posedge clk_i) disable iff (!rst_n_i)
        blk_end && status_clr_tc |=> status.block_done_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat set"); // R16
    property p_w1c;
        @(posedge clk_i) disable iff (!rst_n_i)
        status_clr_vld && !len_write |=> !status.next_params_valid_flag;
    endproperty
    a_w1c: assert property (p_w1c) else $error("valid clear failed"); // R10
    property p_rsvd;
        @(posedge clk_i) disable iff (!rst_n_i) s_status_read |=> avs_readdata_o[31:4] == 28'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set"); // R14
endmodule

// file: bench/xfer_seq_model.sv
`timescale 1ns/10ps
// Transfer sequencer stand-in: issues a commanded number of transfer-done pulses.
module xfer_seq_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [7:0] count_i,
    input wire logic [3:0] gap_i,
    input wire logic channel_active_i,
    output logic xfer_done_o,
    output logic busy_o
);
    logic [7:0] left;
    logic [3:0] wait_cnt;

    // Pulses are spaced by gap idle cycles and only issued while the channel is active.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left <= 8'h00;
            wait_cnt <= 4'h0;
            xfer_done_o <= 1'b0;
        end else begin
            xfer_done_o <= 1'b0;
            if (start_i) begin
                left <= count_i;
                wait_cnt <= gap_i;
            end else if (left != 8'h00 && channel_active_i) begin
                if (wait_cnt != 4'h0) begin
                    wait_cnt <= wait_cnt - 4'h1;
                end else begin
                    xfer_done_o <= 1'b1;
                    left <= left - 8'h01;
                    wait_cnt <= gap_i;
                end
            end
        end
    end

    // Busy until the last pulse has been issued.
    assign busy_o = (left != 8'h00) || xfer_done_o;
endmodule

// file: bench/test_dma_channel_status_logic.sv
`timescale 1ns/10ps
`include "dma_status_map.svh"
// Self-checking bench for the channel status block.
module test_dma_channel_status_logic;
    import dma_status_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic xfer_done_i;
    logic channel_active_o;
    logic irq_o;
    logic [23:0] work_a;
    logic [23:0] work_b;
    logic [15:0] counter;
    logic start = 1'b0;
    logic [7:0] count = 8'h00;
    logic [3:0] gap = 4'h0;
    logic busy;
    logic [31:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;

    // Clock at 200 MHz.
    always #2.5 clk_i = ~clk_i;

    dma_channel_status_logic dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .xfer_done_i(xfer_done_i), .channel_active_o(channel_active_o), .irq_o(irq_o),
        .working_dev_a_address_o(work_a), .working_dev_b_address_o(work_b),
        .remaining_transfer_counter_o(counter));

    xfer_seq_model seq_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start),
        .count_i(count), .gap_i(gap), .channel_active_i(channel_active_o),
        .xfer_done_o(xfer_done_i), .busy_o(busy));

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; the request is held until a rising edge samples waitrequest low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        if (n >= 100) n_mismatch++;
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Commands the sequencer and waits for its last pulse to land.
    task automatic run_xfers(input logic [7:0] n, input logic [3:0] g);
        int k;
        @(posedge clk_i);
        start <= 1'b1;
        count <= n;
        gap <= g;
        @(posedge clk_i);
        start <= 1'b0;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (busy !== 1'b0 && k < 300);
        if (k >= 300) n_mismatch++;
        @(negedge clk_i);
    endtask

    // Reset values, reserved bits and an unmapped offset.
    task automatic t_reset;
        rd_chk(`OFS_STATUS, 32'h0);
        rd_chk(`OFS_CONTROL, 32'h0);
        rd_chk(8'h3c, 32'h0);
        check({31'h0, irq_o}, 32'h0);
    endtask

    // Active flag follows enable and counter and ignores writes.
    task automatic t_active;
        bus(1'b1, `OFS_COUNTER, 32'h3);
        bus(1'b1, `OFS_CONTROL, 32'h01);
        @(negedge clk_i);
        check({31'h0, channel_active_o}, 32'h1);
        bus(1'b1, `OFS_STATUS, 32'h04);
        rd_chk(`OFS_STATUS, 32'h04);
        bus(1'b1, `OFS_CONTROL, 32'h00);
        rd_chk(`OFS_STATUS, 32'h00);
    endtask

    // Buffered block end with no valid parameters, two single-pulse runs with no gap.
    task automatic t_buffered;
        bus(1'b1, `OFS_COUNTER, 32'h2);
        bus(1'b1, `OFS_CONTROL, 32'h01);
        run_xfers(8'h1, 4'h0);
        check({16'h0, counter}, 32'h1);
        run_xfers(8'h1, 4'h0);
        check({31'h0, channel_active_o}, 32'h0);
        rd_chk(`OFS_STATUS, 32'h03);
        bus(1'b1, `OFS_STATUS, 32'h00);
        rd_chk(`OFS_STATUS, 32'h03);
        bus(1'b1, `OFS_STATUS, 32'h03);
        rd_chk(`OFS_STATUS, 32'h00);
    endtask

    // Double-buffer reload, fly-by then memory-to-memory, with a slow sequencer.
    task automatic t_reload(input logic ind, input logic [23:0] b_exp);
        bus(1'b1, `OFS_NEXT_A, 32'h0012_3456);
        bus(1'b1, `OFS_NEXT_B, 32'h00ab_cdef);
        bus(1'b1, `OFS_NEXT_LEN, 32'h5);
        rd_chk(`OFS_STATUS, 32'h08);
        bus(1'b1, `OFS_COUNTER, 32'h1);
        bus(1'b1, `OFS_CONTROL, {27'h0, ind, 4'h1});
        run_xfers(8'h1, 4'h3);
        check({16'h0, counter}, 32'h5);
        check({8'h0, work_a}, 32'h0012_3456);
        check({8'h0, work_b}, {8'h0, b_exp});
        rd_chk(`OFS_STATUS, 32'h05);
        bus(1'b1, `OFS_CONTROL, 32'h00);
        bus(1'b1, `OFS_STATUS, 32'h01);
    endtask

    // Auto-initialize overrun only while block done is still set.
    task automatic t_autoinit;
        bus(1'b1, `OFS_NEXT_LEN, 32'h2);
        bus(1'b1, `OFS_STATUS, 32'h08);
        rd_chk(`OFS_STATUS, 32'h00);
        bus(1'b1, `OFS_COUNTER, 32'h1);
        bus(1'b1, `OFS_CONTROL, 32'h41);
        run_xfers(8'h1, 4'h1);
        rd_chk(`OFS_STATUS, 32'h01);
        bus(1'b1, `OFS_COUNTER, 32'h1);
        run_xfers(8'h1, 4'h1);
        rd_chk(`OFS_STATUS, 32'h03);
        bus(1'b1, `OFS_COUNTER, 32'h1);
        // The status clear lands on the same edge as the block end; the set must win.
        fork
            run_xfers(8'h1, 4'h0);
            begin
                @(posedge clk_i);
                bus(1'b1, `OFS_STATUS, 32'h01);
            end
        join
        rd_chk(`OFS_STATUS, 32'h03);
    endtask

    // Interrupt output against enables, status view and clear register.
    task automatic t_irq;
        bus(1'b1, `OFS_CONTROL, 32'h04);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        bus(1'b1, `OFS_CONTROL, 32'h02);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        bus(1'b1, `OFS_CONTROL, 32'h00);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        bus(1'b1, `OFS_IRQ_ENABLE, 32'h02);
        rd_chk(`OFS_CONTROL, 32'h04);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        bus(1'b1, `OFS_CONTROL, 32'h04);
        bus(1'b1, `OFS_IRQ_CLEAR, 32'h02);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd_chk(`OFS_IRQ_STATUS, 32'h01);
        bus(1'b1, `OFS_IRQ_CLEAR, 32'h01);
        rd_chk(`OFS_STATUS, 32'h00);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_active();
        t_buffered();
        t_reload(1'b0, 24'h00_0000);
        t_reload(1'b1, 24'hab_cdef);
        t_autoinit();
        t_irq();
        wrap_up();
    end

    // Watchdog far beyond the expected run of a few hundred cycles.
    initial begin
        #50000;
        n_mismatch++;
        wrap_up();
    end
endmodule
